// file: rtl/timer16_interval_event_ppg.sv
// 16-bit timer channel: interval timer, event counter and square-wave output
// ********************************************************
// What this block does
// - interval mode raises the match interrupt periodically, period from compare b
// - event mode counts each rising edge of the external count pin
// - software capture copies the running counter into a readable register
// - output flop toggles on a match with compare a or compare b
// - output initial level is programmable, giving high- or low-active pulses
// - with double buffer on, buffer moves into compare a at compare b match
// - only compare a is buffered; compare b writes act at once
// - run control bit 7 enables or disables the compare a buffer
// - compare a holds the 16-bit duty point, compare b the cycle end
// - flop control holds two toggle enables and an initial-level field
// - clock select codes 01, 10, 11 pick prescaler taps; capture can be off
// - clock select can pick the external pin, forming the event counter
// ********************************************************
module timer16_interval_event_ppg
    import timer16_pkg::*;
(
    input  wire logic                  clk_sys,             // system clock, 20 MHz
    input  wire logic                  nrst,                // synchronous reset, active low
    input  wire logic                  module_enable,       // channel control bit 7
    input  wire logic                  count_run,           // run control: counter runs
    input  wire logic                  prescaler_run_bit,   // run control: prescaler runs
    input  wire logic                  dbuf_enable,         // run control bit 7: compare a buffer
    input  wire timer16_pkg::clk_sel_t clk_sel,             // mode: count clock source
    input  wire timer16_pkg::cap_ctrl_t cap_ctrl,           // mode: capture control
    input  wire logic                  soft_capture,        // pulse: capture counter now
    input  wire logic                  toggle_on_a_en,      // flop control: toggle on a match
    input  wire logic                  toggle_on_b_en,      // flop control: toggle on b match
    input  wire logic                  flop_init_we,        // pulse: load flop initial level
    input  wire logic                  flop_init_level,     // level loaded by flop_init_we
    input  wire logic                  compare_a_we,        // pulse: write compare a
    input  wire logic [15:0]           compare_a_wdata,     // compare a write data
    input  wire logic                  compare_b_we,        // pulse: write compare b
    input  wire logic [15:0]           compare_b_wdata,     // compare b write data
    input  wire logic                  external_count_pin,  // asynchronous event input
    output logic [15:0]                counter_value,       // up-counter state
    output logic [15:0]                capture_value,       // last captured count
    output logic [15:0]                compare_reg_a,       // active duty compare
    output logic [15:0]                compare_reg_b,       // cycle compare
    output logic                       channel_match_irq,   // one-cycle pulse per period
    output logic                       square_wave_out_pin  // output toggle flop level
);

    // ********************************************************
    // count clock selection
    // ********************************************************
    logic pin_rise;
    logic tap1;
    logic tap2;
    logic tap3;
    logic running;
    logic tick;

    timer16_pin_edge u_pin_edge (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .pin_in  (external_count_pin),
        .rise_p  (pin_rise)
    );

    // the pin path also needs the prescaler running, matching the software contract
    timer16_prescaler u_prescaler (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .run     (prescaler_run_bit & module_enable),
        .tap1_p  (tap1),
        .tap2_p  (tap2),
        .tap3_p  (tap3)
    );

    assign running = module_enable & count_run & prescaler_run_bit;

    always_comb begin
        tick = 1'b0;
        case (clk_sel)
            CLK_EXT_PIN: tick = running & pin_rise;
            CLK_TAP1:    tick = running & tap1;
            CLK_TAP2:    tick = running & tap2;
            CLK_TAP3:    tick = running & tap3;
            default:     tick = 1'b0;
        endcase
    end

    // ********************************************************
    // compare registers and double buffer
    // ********************************************************
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] cmp_a_r;
    logic [CNT_W-1:0] cmp_b_r;
    logic [CNT_W-1:0] abuf_r;
    logic             match_a;
    logic             match_b;

    function automatic logic cmp_hit(input logic [15:0] c, input logic [15:0] v);
        cmp_hit = (c == v);
    endfunction : cmp_hit

    assign match_a = tick & cmp_hit(cnt_r, cmp_a_r);
    assign match_b = tick & cmp_hit(cnt_r, cmp_b_r);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            abuf_r <= CMP_RST;
        end else if (compare_a_we) begin
            abuf_r <= compare_a_wdata;
        end
    end

    // a direct write beats a pending buffer transfer in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cmp_a_r <= CMP_RST;
        end else if (compare_a_we && !dbuf_enable) begin
            cmp_a_r <= compare_a_wdata;
        end else if (dbuf_enable && match_b) begin
            cmp_a_r <= compare_a_we ? compare_a_wdata : abuf_r;
        end
    end

    // unbuffered: a change mid-period moves this period's end point
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cmp_b_r <= CMP_RST;
        end else if (compare_b_we) begin
            cmp_b_r <= compare_b_wdata;
        end
    end

    // ********************************************************
    // up-counter and period interrupt
    // ********************************************************
    always_comb begin
        cnt_nxt = cnt_r;
        if (!running) begin
            cnt_nxt = CNT_RST;
        end else if (match_b) begin
            cnt_nxt = CNT_RST;
        end else if (tick) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_r <= CNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            channel_match_irq <= 1'b0;
        end else begin
            channel_match_irq <= match_b;
        end
    end

    // ********************************************************
    // software capture
    // ********************************************************
    // counter keeps running; the capture is a snapshot
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            capture_value <= CNT_RST;
        end else if (soft_capture && cap_ctrl != CAP_OFF) begin
            capture_value <= cnt_r;
        end
    end

    // ********************************************************
    // output toggle flop
    // ********************************************************
    logic flop_r;
    logic do_toggle;

    assign do_toggle = (match_a & toggle_on_a_en) | (match_b & toggle_on_b_en);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            flop_r <= 1'b0;
        end else if (flop_init_we) begin
            flop_r <= flop_init_level;
        end else if (do_toggle) begin
            flop_r <= ~flop_r;
        end
    end

    assign counter_value       = cnt_r;
    assign compare_reg_a       = cmp_a_r;
    assign compare_reg_b       = cmp_b_r;
    assign square_wave_out_pin = flop_r;

    // ********************************************************
    // assertions
    // ********************************************************
    a_irq_on_b: assert property (@(posedge clk_sys) disable iff (!nrst)
        (tick && cnt_r == cmp_b_r) |=> channel_match_irq)
        else $error("match interrupt missing after compare b match");

    a_irq_cause: assert property (@(posedge clk_sys) disable iff (!nrst)
        channel_match_irq |-> $past(match_b) && cnt_r == CNT_RST)
        else $error("match interrupt without a compare b match");

    a_wrap_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        match_b |=> cnt_r == CNT_RST)
        else $error("counter did not clear after compare b match");

    a_event_count: assert property (@(posedge clk_sys) disable iff (!nrst)
        (running && clk_sel == CLK_EXT_PIN && pin_rise && cnt_r != cmp_b_r)
        |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("event edge not counted");

    a_no_spurious: assert property (@(posedge clk_sys) disable iff (!nrst)
        (running && $past(running) && !$past(tick)) |-> cnt_r == $past(cnt_r))
        else $error("counter moved without a count tick");

    a_capture_snap: assert property (@(posedge clk_sys) disable iff (!nrst)
        (soft_capture && cap_ctrl != CAP_OFF) |=> capture_value == $past(cnt_r))
        else $error("capture value wrong");

    a_capture_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        (cap_ctrl == CAP_OFF) |=> $stable(capture_value))
        else $error("capture taken while disabled");

    a_toggle_flop: assert property (@(posedge clk_sys) disable iff (!nrst)
        (do_toggle && !flop_init_we) |=> square_wave_out_pin != $past(square_wave_out_pin))
        else $error("output flop did not toggle on match");

    a_flop_init: assert property (@(posedge clk_sys) disable iff (!nrst)
        flop_init_we |=> square_wave_out_pin == $past(flop_init_level))
        else $error("flop initial level not loaded");

    a_dbuf_load: assert property (@(posedge clk_sys) disable iff (!nrst)
        (dbuf_enable && match_b && !compare_a_we) |=> compare_reg_a == $past(abuf_r))
        else $error("buffer not moved into compare a");

    a_dbuf_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        (dbuf_enable && !match_b) |=> $stable(compare_reg_a))
        else $error("buffered compare a changed mid-period");

    a_b_direct: assert property (@(posedge clk_sys) disable iff (!nrst)
        compare_b_we |=> compare_reg_b == $past(compare_b_wdata))
        else $error("compare b write not applied at once");

    // tick spacing assumes software stops the counter before it changes the clock source
    a_stop_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
        !running |=> cnt_r == CNT_RST)
        else $error("stopped counter not cleared");

    a_irq_single: assert property (@(posedge clk_sys) disable iff (!nrst)
        channel_match_irq |=> !channel_match_irq)
        else $error("match interrupt longer than one cycle");

    a_irq_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
        !match_b |=> !channel_match_irq)
        else $error("match interrupt without cause");

    a_b_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        !compare_b_we |=> $stable(compare_reg_b))
        else $error("compare b changed without a write");

    a_a_direct: assert property (@(posedge clk_sys) disable iff (!nrst)
        (compare_a_we && !dbuf_enable) |=> compare_reg_a == $past(compare_a_wdata))
        else $error("unbuffered compare a write not applied");

    a_buf_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        compare_a_we |=> abuf_r == $past(compare_a_wdata))
        else $error("compare a buffer not written");

    a_flop_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        (!do_toggle && !flop_init_we) |=> $stable(square_wave_out_pin))
        else $error("output flop moved without a match");

    a_tap_gap: assert property (@(posedge clk_sys) disable iff (!nrst)
        (tick && clk_sel != CLK_EXT_PIN) |=> !tick)
        else $error("prescaler tick on two cycles in a row");

    a_pin_only: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clk_sel == CLK_EXT_PIN && tick) |-> pin_rise)
        else $error("pin mode counted without a pin edge");

    a_cap_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        !soft_capture |=> $stable(capture_value))
        else $error("capture value changed without a request");

    a_count_up: assert property (@(posedge clk_sys) disable iff (!nrst)
        (tick && !match_b) |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("counter did not advance on a tick");

    c_period_irq: cover property (@(posedge clk_sys) disable iff (!nrst)
        channel_match_irq ##[1:200] channel_match_irq);
    c_square_wave: cover property (@(posedge clk_sys) disable iff (!nrst)
        match_a && toggle_on_a_en ##[1:200] match_b && toggle_on_b_en);
    c_dbuf_swap: cover property (@(posedge clk_sys) disable iff (!nrst)
        dbuf_enable && match_b && abuf_r != cmp_a_r);
    c_event_capture: cover property (@(posedge clk_sys) disable iff (!nrst)
        clk_sel == CLK_EXT_PIN && tick ##[1:50] soft_capture && cap_ctrl != CAP_OFF);

endmodule : timer16_interval_event_ppg

// file: rtl/timer16_pkg.sv
// shared constants and types for the 16-bit timer channel
package timer16_pkg;

    // ********************************************************
    // widths and reset values
    // ********************************************************
    localparam int          CNT_W      = 16;
    localparam int          PRE_W      = 6;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [15:0] CMP_RST    = 16'hFFFF;
    localparam logic [5:0]  PRE_RST    = 6'h00;

    // ********************************************************
    // prescaler tap positions (divide by 2, 8, 32)
    // ********************************************************
    localparam int          TAP1_BIT   = 0;
    localparam int          TAP2_BIT   = 2;
    localparam int          TAP3_BIT   = 4;

    // ********************************************************
    // mode select fields
    // ********************************************************
    typedef enum logic [1:0] {
        CLK_EXT_PIN = 2'h0,
        CLK_TAP1    = 2'h1,
        CLK_TAP2    = 2'h2,
        CLK_TAP3    = 2'h3
    } clk_sel_t;

    typedef enum logic [1:0] {
        CAP_OFF     = 2'h0,
        CAP_SOFT    = 2'h1,
        CAP_RSVD2   = 2'h2,
        CAP_RSVD3   = 2'h3
    } cap_ctrl_t;

endpackage : timer16_pkg

// file: rtl/timer16_pin_edge.sv
// two-flop synchroniser and rising-edge detector for the external count pin
module timer16_pin_edge (
    input  wire logic clk_sys,   // system clock
    input  wire logic nrst,      // synchronous reset, active low
    input  wire logic pin_in,    // asynchronous pin level
    output logic      rise_p     // one-cycle pulse on a rising edge
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // first flop feeds only the second one
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign rise_p = sync_r & ~last_r;
endmodule : timer16_pin_edge

// file: rtl/timer16_prescaler.sv
// free-running prescaler with three divided tick taps
module timer16_prescaler
    import timer16_pkg::*;
(
    input  wire logic clk_sys,   // system clock
    input  wire logic nrst,      // synchronous reset, active low
    input  wire logic run,       // prescaler runs while high
    output logic      tap1_p,    // tick every 2 clocks
    output logic      tap2_p,    // tick every 8 clocks
    output logic      tap3_p     // tick every 32 clocks
);
    logic [PRE_W-1:0] div_r;
    logic [PRE_W-1:0] div_nxt;

    always_comb begin
        div_nxt = div_r + 6'h01;
    end

    // a stopped prescaler restarts from zero so the first tick is a full period
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            div_r <= PRE_RST;
        end else if (run) begin
            div_r <= div_nxt;
        end else begin
            div_r <= PRE_RST;
        end
    end

    // a tap fires when every bit below and at its position carries out
    assign tap1_p = run & (&div_r[TAP1_BIT:0]);
    assign tap2_p = run & (&div_r[TAP2_BIT:0]);
    assign tap3_p = run & (&div_r[TAP3_BIT:0]);
endmodule : timer16_prescaler

// file: bench/timer16_pin_partner.sv
// pin-side model: drives the external count pin and watches the square-wave pin
module timer16_pin_partner (
    input  wire logic clk_sys,             // system clock
    output logic      external_count_pin,  // event pulses into the channel
    input  wire logic square_wave_out_pin  // observed output flop
);
    timeunit 1ns;
    timeprecision 1ns;

    int rises_seen = 0;

    initial external_count_pin = 1'b0;

    // 3 clocks high, 2 low: wide enough that the two-flop synchroniser never drops an edge
    task automatic send_pulses(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            external_count_pin = 1'b1;
            repeat (3) @(negedge clk_sys);
            external_count_pin = 1'b0;
            repeat (1) @(negedge clk_sys);
        end
    endtask : send_pulses

    always @(posedge square_wave_out_pin) rises_seen++;
endmodule : timer16_pin_partner

// file: bench/timer16_interval_event_ppg_tb_top.sv
// self-checking bench for the 16-bit timer channel
module timer16_interval_event_ppg_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import timer16_pkg::*;

    logic clk_sys = 1'b0, nrst = 1'b0, module_enable = 1'b0, count_run = 1'b0, prescaler_run_bit = 1'b0;
    logic dbuf_enable = 1'b0, soft_capture = 1'b0, toggle_on_a_en = 1'b0, toggle_on_b_en = 1'b0;
    logic flop_init_we = 1'b0, flop_init_level = 1'b0, compare_a_we = 1'b0, compare_b_we = 1'b0;
    logic [15:0] compare_a_wdata = 16'h0000, compare_b_wdata = 16'h0000;
    logic [15:0] counter_value, capture_value, compare_reg_a, compare_reg_b;
    logic        external_count_pin, channel_match_irq, square_wave_out_pin;
    clk_sel_t    clk_sel = CLK_TAP1;
    cap_ctrl_t   cap_ctrl = CAP_OFF;
    int          fail_count = 0, total_checks = 0, cycles = 0, n;

    typedef struct { clk_sel_t sel; logic [15:0] cmp_b; int period; } row_t;
    // period in system clocks = (compare b + 1) * tap divide
    row_t rows [4] = '{'{CLK_TAP1, 16'h0003, 8}, '{CLK_TAP2, 16'h0001, 16},
                       '{CLK_TAP3, 16'h0000, 32}, '{CLK_TAP1, 16'h0000, 2}};

    always #25 clk_sys = ~clk_sys;

    timer16_interval_event_ppg i_dut (.clk_sys(clk_sys), .nrst(nrst), .module_enable(module_enable),
        .count_run(count_run), .prescaler_run_bit(prescaler_run_bit), .dbuf_enable(dbuf_enable),
        .clk_sel(clk_sel), .cap_ctrl(cap_ctrl), .soft_capture(soft_capture), .toggle_on_a_en(toggle_on_a_en),
        .toggle_on_b_en(toggle_on_b_en), .flop_init_we(flop_init_we), .flop_init_level(flop_init_level),
        .compare_a_we(compare_a_we), .compare_a_wdata(compare_a_wdata), .compare_b_we(compare_b_we),
        .compare_b_wdata(compare_b_wdata), .external_count_pin(external_count_pin),
        .counter_value(counter_value), .capture_value(capture_value), .compare_reg_a(compare_reg_a),
        .compare_reg_b(compare_reg_b), .channel_match_irq(channel_match_irq),
        .square_wave_out_pin(square_wave_out_pin));

    timer16_pin_partner i_pin (.clk_sys(clk_sys), .external_count_pin(external_count_pin),
        .square_wave_out_pin(square_wave_out_pin));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // a hang here is cut short by the cycle ceiling below
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    // whole 16-bit words, so the low-then-high byte order never splits a value
    task automatic wr(input bit sel_b, input logic [15:0] v);
        @(negedge clk_sys);
        if (sel_b) begin compare_b_we = 1'b1; compare_b_wdata = v; end
        else begin compare_a_we = 1'b1; compare_a_wdata = v; end
        @(negedge clk_sys);
        compare_a_we = 1'b0;
        compare_b_we = 1'b0;
    endtask : wr

    task automatic wait_irq(output int k);
        k = 0;
        do begin @(posedge clk_sys); #1; k++; end while (channel_match_irq !== 1'b1 && k < 400);
    endtask : wait_irq

    // counts clocks while the output stays at lvl; stops on the first clock it differs
    task automatic wait_lvl(input logic lvl, output int k);
        k = 0;
        do begin @(posedge clk_sys); #1; k++; end while (square_wave_out_pin === lvl && k < 400);
    endtask : wait_lvl

    task automatic pulse_capture();
        @(negedge clk_sys) soft_capture = 1'b1;
        @(negedge clk_sys) soft_capture = 1'b0;
    endtask : pulse_capture

    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) nrst = 1'b1;
        check("counter", counter_value, 16'h0000);
        check("compare_b", compare_reg_b, 16'hFFFF);
        check("irq", {15'h0000, channel_match_irq}, 16'h0000);
        $display("test reset done");
        module_enable = 1'b1;
        prescaler_run_bit = 1'b1;
        foreach (rows[i]) begin
            @(negedge clk_sys) count_run = 1'b0;
            clk_sel = rows[i].sel;
            wr(1'b1, rows[i].cmp_b);
            count_run = 1'b1;
            wait_irq(n);
            wait_irq(n);
            check("irq_period", 16'(n), 16'(rows[i].period));
            $display("test interval row %0d done", i);
        end
        @(negedge clk_sys) count_run = 1'b0;
        clk_sel = CLK_EXT_PIN;
        cap_ctrl = CAP_SOFT;
        wr(1'b1, 16'hFFFF);
        count_run = 1'b1;
        i_pin.send_pulses(5);
        repeat (6) @(negedge clk_sys);
        check("event_count", counter_value, 16'h0005);
        pulse_capture();
        check("capture", capture_value, 16'h0005);
        cap_ctrl = CAP_OFF;
        i_pin.send_pulses(2);
        repeat (6) @(negedge clk_sys);
        pulse_capture();
        check("capture_off", capture_value, 16'h0005);
        check("event_count2", counter_value, 16'h0007);
        $display("test event counter done");
        @(negedge clk_sys) count_run = 1'b0;
        clk_sel = CLK_TAP1;
        toggle_on_a_en = 1'b1;
        toggle_on_b_en = 1'b1;
        wr(1'b0, 16'h0001);
        wr(1'b1, 16'h0005);
        count_run = 1'b1;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        check("high_time", 16'(n), 16'h0008);
        wait_lvl(1'b0, n);
        check("low_time", 16'(n), 16'h0004);
        @(negedge clk_sys) count_run = 1'b0;
        flop_init_we = 1'b1;
        flop_init_level = 1'b1;
        @(negedge clk_sys) flop_init_we = 1'b0;
        check("init_level", {15'h0000, square_wave_out_pin}, 16'h0001);
        count_run = 1'b1;
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        check("low_active", 16'(n), 16'h0008);
        check("partner_rises", 16'(i_pin.rises_seen > 0), 16'h0001);
        $display("test square wave done");
        @(negedge clk_sys) dbuf_enable = 1'b1;
        wait_irq(n);
        wr(1'b0, 16'h0003);
        check("a_buffered", compare_reg_a, 16'h0001);
        wait_irq(n);
        check("a_loaded", compare_reg_a, 16'h0003);
        wr(1'b1, 16'h0007);
        check("b_direct", compare_reg_b, 16'h0007);
        dbuf_enable = 1'b0;
        wr(1'b0, 16'h0002);
        check("a_direct", compare_reg_a, 16'h0002);
        $display("test double buffer done");
        @(negedge clk_sys) count_run = 1'b0;
        clk_sel = CLK_EXT_PIN;
        flop_init_we = 1'b1;
        @(negedge clk_sys) flop_init_level = 1'b0;
        @(negedge clk_sys) flop_init_we = 1'b0;
        check("init_zero", {15'h0000, square_wave_out_pin}, 16'h0000);
        prescaler_run_bit = 1'b0;
        count_run = 1'b1;
        i_pin.send_pulses(2);
        repeat (6) @(negedge clk_sys);
        check("no_prescaler", counter_value, 16'h0000);
        prescaler_run_bit = 1'b1;
        i_pin.send_pulses(3);
        repeat (6) @(negedge clk_sys);
        check("prescaler_on", counter_value, 16'h0003);
        module_enable = 1'b0;
        @(negedge clk_sys);
        check("disabled", counter_value, 16'h0000);
        $display("test stop controls done");
        print_verdict();
    end
endmodule : timer16_interval_event_ppg_tb_top
